// ==== bench/bus_master_model.sv ====
`timescale 1ns/100ps
module bus_master_model
(
  input wire logic clk_in,
  input wire logic xack_b_in,
  input wire logic [15:0] dat_in,
  output logic mrdc_b_out,
  output logic iord_b_out,
  output logic iowc_b_out,
  output logic bhen_b_out,
  output logic [23:0] adr_out,
  output logic [15:0] got_out
);
  event took;
  initial
  begin
    {mrdc_b_out, iord_b_out, iowc_b_out, bhen_b_out} = 4'hF;
    adr_out = 24'h000000;
    got_out = 16'h0000;
  end
  // Kind 0 memory read, 1 register read, 2 register write; bounded wait for ack
  task automatic xfer(input int kind, input logic [23:0] a, input logic bh, output logic acked);
    acked = 1'b0;
    @(negedge clk_in);
    adr_out = a;
    bhen_b_out = bh;
    mrdc_b_out = (kind != 0);
    iord_b_out = (kind != 1);
    iowc_b_out = (kind != 2);
    for (int i = 0; i < 16 && !acked; i++)
    begin
      @(posedge clk_in);
      if (xack_b_in === 1'b0)
      begin
        acked = 1'b1;
        got_out = dat_in;
        if (kind != 2)
          -> took;
      end
    end
    @(negedge clk_in);
    {mrdc_b_out, iord_b_out, iowc_b_out, bhen_b_out} = 4'hF;
    // Released address lines do not keep the old value
    adr_out = ~a;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// ==== bench/tb_parity_error_logger.sv ====
`timescale 1ns/100ps
module tb_parity_error_logger;
  localparam logic [13:0] START = 14'h0010;
  localparam logic [13:0] LAST = 14'h020F;
  localparam logic [15:0] IO = 16'h0042;
  logic clk_in, rst_b_in, init_b_in, mrdc_b, iord_b, iowc_b, bhen_b, dat_oe, xack_b, ack;
  logic led_lo, led_hi, led_b0, led_b1;
  logic [23:0] adr;
  logic [15:0] mem_data, dat, got, lfsr;
  logic [1:0] mem_par;
  logic [7:0] int_oe;
  logic int_en;
  logic [2:0] int_sel;
  logic [15:0] expq[$];
  logic [15:0] maskq[$];
  int error_cnt, comparisons, cyc;
  parity_error_logger dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .init_b_in(init_b_in),
    .mrdc_b_in(mrdc_b), .iord_b_in(iord_b), .iowc_b_in(iowc_b), .bhen_b_in(bhen_b),
    .adr_in(adr), .start_kb_in(START), .end_kb_in(LAST), .io_base_in(IO),
    .int_en_in(int_en), .int_sel_in(int_sel), .mem_data_in(mem_data), .mem_par_in(mem_par),
    .dat_out(dat), .dat_oe_out(dat_oe), .xack_b_out(xack_b), .int_oe_out(int_oe),
    .low_lane_error_led_out(led_lo), .high_lane_error_led_out(led_hi),
    .bank_lsb_led_out(led_b0), .bank_msb_led_out(led_b1));
  bus_master_model m (.clk_in(clk_in), .xack_b_in(xack_b), .dat_in(dat), .mrdc_b_out(mrdc_b),
    .iord_b_out(iord_b), .iowc_b_out(iowc_b), .bhen_b_out(bhen_b), .adr_out(adr), .got_out(got));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(input logic [3:0] leds, input logic [7:0] irq);
    chk("leds", {12'h000, leds}, {12'h000, led_b1, led_b0, led_hi, led_lo});
    chk("irq", {8'h00, irq}, {8'h00, int_oe});
  endtask
  task automatic mem_read(input logic [8:0] ofs, input logic [1:0] bad, input logic bh,
    input logic a0);
    logic [15:0] d;
    logic [15:0] r;
    d = rnd();
    r = rnd();
    @(negedge clk_in);
    mem_data = d;
    mem_par = {~^d[15:8] ^ bad[1], ~^d[7:0] ^ bad[0]};
    if (!bh)
      expq.push_back(d);
    else if (a0)
      expq.push_back({d[15:8], d[15:8]});
    else
      expq.push_back({8'h00, d[7:0]});
    maskq.push_back((bh && !a0) ? 16'h00FF : 16'hFFFF);
    m.xfer(0, {START + {5'h00, ofs}, r[9:1], a0}, bh, ack);
    chk("ack", 16'h0001, {15'h0000, ack});
  endtask
  task automatic reg_read(input logic [7:0] e);
    expq.push_back({8'h00, e});
    maskq.push_back(16'hFFFF);
    m.xfer(1, {8'h00, IO}, 1'b1, ack);
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Oldest note is matched against each captured read
  initial
  forever
  begin
    @(m.took);
    // Let the captured word reach the port net before it is read
    #1;
    chk("oe", 16'h0001, {15'h0000, dat_oe});
    if (expq.size() == 0)
      chk("queue", 16'h0000, 16'hFFFF);
    else
      chk("data", expq.pop_front(), got & maskq.pop_front());
  end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    lfsr = 16'h0063;
    rst_b_in = 1'b0;
    init_b_in = 1'b1;
    int_en = 1'b1;
    int_sel = 3'h5;
    mem_data = 16'h0000;
    mem_par = 2'h0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    chk_out(4'h0, 8'h00);
    m.xfer(2, {8'h00, IO}, 1'b1, ack);
    mem_read({2'h2, 7'h15}, 2'b00, 1'b0, 1'b0);
    chk_out(4'h8, 8'h00);
    reg_read(8'h08);
    mem_read({2'h1, 7'h03}, 2'b01, 1'b1, 1'b0);
    chk_out(4'h5, 8'h20);
    mem_read({2'h3, 7'h40}, 2'b00, 1'b0, 1'b0);
    chk_out(4'h5, 8'h20);
    mem_read({2'h0, 7'h01}, 2'b10, 1'b1, 1'b1);
    chk_out(4'h7, 8'h20);
    reg_read(8'h07);
    m.xfer(2, {8'h00, IO}, 1'b0, ack);
    chk_out(4'h4, 8'h00);
    reg_read(8'h04);
    mem_read(9'h1FF, 2'b00, 1'b0, 1'b0);
    chk_out(4'hC, 8'h00);
    m.xfer(0, {LAST + 14'h0001, 10'h000}, 1'b0, ack);
    chk("ack", 16'h0000, {15'h0000, ack});
    m.xfer(0, {START - 14'h0001, 10'h3FE}, 1'b0, ack);
    chk("ack", 16'h0000, {15'h0000, ack});
    mem_read({2'h1, 7'h22}, 2'b11, 1'b0, 1'b0);
    chk_out(4'h7, 8'h20);
    @(negedge clk_in);
    int_en = 1'b0;
    repeat (2) @(negedge clk_in);
    chk_out(4'h7, 8'h00);
    int_en = 1'b1;
    int_sel = 3'h2;
    repeat (2) @(negedge clk_in);
    chk_out(4'h7, 8'h04);
    @(negedge clk_in);
    init_b_in = 1'b0;
    m.xfer(1, {8'h00, IO}, 1'b1, ack);
    chk("ack", 16'h0000, {15'h0000, ack});
    init_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk_out(4'h4, 8'h00);
    chk("left", 16'h0000, 16'(expq.size()));
    report_and_stop();
  end
endmodule

// ==== verilog/lane_parity_check.sv ====
`timescale 1ns/100ps
`include "parity_logger_defines.svh"

module lane_parity_check
  import parity_logger_pkg::*;
(
  input wire logic [15:0] data_in,
  input wire logic [1:0] par_in,
  input wire logic [1:0] lane_used_in,
  output logic [1:0] lane_err_out
);

  genvar g;
  generate
    for (g = 0; g < `LANE_COUNT; g++)
    begin : g_lane
      // Odd parity: byte plus stored bit must hold an odd number of ones
      assign lane_err_out[g] = lane_used_in[g] &
        ((^{data_in[g*8 +: 8], par_in[g]}) != `ODD_PARITY); // R15
    end
  endgenerate

endmodule

// ==== verilog/parity_error_logger.sv ====
// Contract
// (R1) On memory read, drive data first, then assert the transfer acknowledge.
// (R2) Master takes data on acknowledge, then drops the read command.
// (R3) Parity error latches failing lane and bank into register and indicators.
// (R4) Captured error holds until initialization or a register write.
// (R5) With interrupt enabled, a held error asserts the selected request line.
// (R6) Interrupt handler writes the register address to clear the error.
// (R7) Separate indicators light for low lane and high lane errors.
// (R8) Two bank indicators show bank number in binary, lsb and msb.
// (R9) Bank indicators track accessed bank, freeze on failing access bank.
// (R10) Any write to the register address clears it, data ignored. Code clears only the two error flags; the bank bits keep their value.
// (R11) Software clears the register after power-up and after each error.
// (R12) Register read: low flag bit0, high flag bit1, bank lsb, bank msb.
// (R13) Ending address setting is the last owned kilobyte, inclusive.
// (R14) While initialization is low, all bus commands are ignored.
// (R15) Each lane's parity is checked on every read; mismatch sets its flag. Code checks only the lanes the access uses, on memory reads only.
// (R16) Upper four register bits read as zero.
`timescale 1ns/100ps
`include "parity_logger_defines.svh"

module parity_error_logger
  import parity_logger_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic init_b_in,
  input wire logic mrdc_b_in,
  input wire logic iord_b_in,
  input wire logic iowc_b_in,
  input wire logic bhen_b_in,
  input wire logic [23:0] adr_in,
  input wire logic [13:0] start_kb_in,
  input wire logic [13:0] end_kb_in,
  input wire logic [15:0] io_base_in,
  input wire logic int_en_in,
  input wire logic [2:0] int_sel_in,
  input wire logic [15:0] mem_data_in,
  input wire logic [1:0] mem_par_in,
  output logic [15:0] dat_out,
  output logic dat_oe_out,
  output logic xack_b_out,
  output logic [7:0] int_oe_out,
  output logic low_lane_error_led_out,
  output logic high_lane_error_led_out,
  output logic bank_lsb_led_out,
  output logic bank_msb_led_out
);

  state_t st;
  state_t next_st;
  logic [13:0] adr_kb;
  logic [13:0] offset_kb;
  logic mem_hit;
  logic mem_go;
  logic io_hit;
  logic io_rd_go;
  logic io_wr_go;
  logic odd_only;
  logic [1:0] lane_used;
  logic [1:0] lane_err;
  logic [1:0] access_bank;
  logic held;

  assign adr_kb = adr_in[`KB_ADDR_HI:`KB_ADDR_LO];
  assign offset_kb = adr_kb - start_kb_in;
  assign access_bank = offset_kb[`BANK_FIELD_HI:`BANK_FIELD_LO];
  // Inclusive upper compare: the end setting names the last owned kilobyte
  assign mem_hit = (adr_kb >= start_kb_in) && (adr_kb <= end_kb_in); // R13
  assign io_hit = adr_in[`IO_ADDR_HI:0] == io_base_in;
  // Commands are taken only from idle and never while initialization is low
  assign mem_go = (st.phase == ST_IDLE) && init_b_in && !mrdc_b_in && mem_hit; // R14
  assign io_rd_go = (st.phase == ST_IDLE) && init_b_in && !iord_b_in && io_hit; // R14
  assign io_wr_go = (st.phase == ST_IDLE) && init_b_in && !iowc_b_in && io_hit; // R14
  assign odd_only = adr_in[0] && bhen_b_in;
  assign lane_used = {!bhen_b_in || adr_in[0], !odd_only};
  assign held = st.low_flag || st.high_flag;

  lane_parity_check u_check (
    .data_in(mem_data_in),
    .par_in(mem_par_in),
    .lane_used_in(lane_used),
    .lane_err_out(lane_err)
  );

  always_comb
  begin
    next_st = st;
    unique case (st.phase)
      ST_IDLE:
      begin
        if (mem_go)
        begin
          next_st.phase = ST_DRIVE;
          next_st.io_rd = 1'b0;
          next_st.dat_oe = 1'b1; // R1
          // Odd byte alone goes out through the swap path on the low lines
          if (odd_only)
            next_st.dat = {mem_data_in[`BYTE_HI:`BYTE_HI_LO],
                           mem_data_in[`BYTE_HI:`BYTE_HI_LO]};
          else
            next_st.dat = mem_data_in;
        end
        else if (io_rd_go)
        begin
          next_st.phase = ST_DRIVE;
          next_st.io_rd = 1'b1;
          next_st.dat_oe = 1'b1;
          next_st.dat = {8'h00, `RPT_UPPER_ZERO, st.bank[1], st.bank[0],
                         st.high_flag, st.low_flag}; // R12 R16
        end
        else if (io_wr_go)
        begin
          next_st.phase = ST_DRIVE;
          next_st.io_rd = 1'b0;
        end
      end
      ST_DRIVE:
      begin
        // Data has stood a full cycle before the acknowledge goes low
        next_st.phase = ST_ACK;
        next_st.xack_b = 1'b0; // R1
      end
      ST_ACK:
      begin
        // Hold until the master drops every command
        if (mrdc_b_in && iord_b_in && iowc_b_in) // R2
        begin
          next_st.phase = ST_IDLE;
          next_st.xack_b = 1'b1;
          next_st.dat_oe = 1'b0;
          next_st.dat = `DATA_RST;
        end
      end
      // The fourth code is never entered; fall back to idle if it appears
      default:
      begin
        next_st.phase = ST_IDLE;
      end
    endcase
    // Any write to the register clears both error flags whatever the data; the bank bits keep their value
    if (io_wr_go) // R10 R6
    begin
      next_st.low_flag = 1'b0;
      next_st.high_flag = 1'b0;
    end
    // Bank readout follows accesses until an error freezes it
    if (mem_go && !held) // R9
      next_st.bank = access_bank;
    // Set wins over a register-write clear; flags are otherwise held
    if (mem_go && (lane_err != 2'h0)) // R3 R4 R15
    begin
      if (lane_err[0])
        next_st.low_flag = 1'b1;
      if (lane_err[1])
        next_st.high_flag = 1'b1;
      if (!held)
        next_st.bank = access_bank;
    end
    // Board initialization drops the bus side and discards held errors
    if (!init_b_in) // R4 R14
    begin
      next_st.phase = ST_IDLE;
      next_st.low_flag = 1'b0;
      next_st.high_flag = 1'b0;
      next_st.xack_b = 1'b1;
      next_st.dat_oe = 1'b0;
      next_st.dat = `DATA_RST;
    end
    next_st.int_oe = `INT_RST;
    if (int_en_in && (next_st.low_flag || next_st.high_flag))
      next_st.int_oe[int_sel_in] = 1'b1; // R5
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st.phase <= ST_IDLE;
      st.low_flag <= 1'b0;
      st.high_flag <= 1'b0;
      st.bank <= `BANK_RST;
      st.io_rd <= 1'b0;
      st.dat <= `DATA_RST;
      st.dat_oe <= 1'b0;
      st.xack_b <= 1'b1;
      st.int_oe <= `INT_RST;
    end
    else
      st <= next_st;
  end

  assign dat_out = st.dat;
  assign dat_oe_out = st.dat_oe;
  assign xack_b_out = st.xack_b;
  assign int_oe_out = st.int_oe;
  assign low_lane_error_led_out = st.low_flag; // R7
  assign high_lane_error_led_out = st.high_flag; // R7
  assign bank_lsb_led_out = st.bank[0]; // R8
  assign bank_msb_led_out = st.bank[1]; // R8

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_data_before_ack;
    $fell(xack_b_out) && !st.io_rd && $past(mem_go, 2) |-> dat_oe_out && $past(dat_oe_out);
  endproperty
  a_data_before_ack: assert property (p_data_before_ack) else $error("ack without data"); // R1

  property p_ack_timing;
    mem_go |=> xack_b_out ##1 !xack_b_out;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack not two cycles after read"); // R1

  property p_low_capture;
    mem_go && lane_err[0] && init_b_in |=> low_lane_error_led_out;
  endproperty
  a_low_capture: assert property (p_low_capture) else $error("low lane error lost"); // R3

  property p_high_capture;
    mem_go && lane_err[1] && init_b_in |=> high_lane_error_led_out;
  endproperty
  a_high_capture: assert property (p_high_capture) else $error("high lane error lost"); // R15

  property p_hold;
    low_lane_error_led_out && init_b_in && !io_wr_go |=> low_lane_error_led_out;
  endproperty
  a_hold: assert property (p_hold) else $error("error flag dropped"); // R4

  property p_clear;
    io_wr_go && init_b_in |=> !low_lane_error_led_out && !high_lane_error_led_out;
  endproperty
  a_clear: assert property (p_clear) else $error("write did not clear"); // R10

  // Request line follows the option and selection one cycle late
  property p_irq;
    int_en_in |=> int_oe_out == ((low_lane_error_led_out || high_lane_error_led_out) ?
      (8'h01 << $past(int_sel_in)) : 8'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // R5

  property p_bank_follow;
    mem_go && !held && lane_err == 2'h0 |=>
      {bank_msb_led_out, bank_lsb_led_out} == $past(access_bank);
  endproperty
  a_bank_follow: assert property (p_bank_follow) else $error("bank not tracked"); // R9

  property p_bank_freeze;
    held && init_b_in && !io_wr_go |=> $stable({bank_msb_led_out, bank_lsb_led_out});
  endproperty
  a_bank_freeze: assert property (p_bank_freeze) else $error("bank not frozen"); // R9

  property p_io_read;
    io_rd_go |=> dat_out[15:4] == 12'h000 && dat_out[3:0] == $past({st.bank, st.high_flag,
      st.low_flag});
  endproperty
  a_io_read: assert property (p_io_read) else $error("register read wrong"); // R12

  property p_init_quiet;
    !init_b_in |=> xack_b_out && !dat_oe_out;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("command during init"); // R14

  property p_range;
    st.phase == ST_IDLE && !mrdc_b_in && iord_b_in && iowc_b_in && adr_kb > end_kb_in |=>
      st.phase == ST_IDLE;
  endproperty
  a_range: assert property (p_range) else $error("out of range read taken"); // R13

  c_mem_read: cover property (mem_go ##2 !xack_b_out);
  c_parity_err: cover property (mem_go && lane_err != 2'h0);
  c_io_clear: cover property (held && io_wr_go);
  c_io_read: cover property (io_rd_go && held);

endmodule

// ==== verilog/parity_logger_defines.svh ====
`ifndef PARITY_LOGGER_DEFINES_SVH
`define PARITY_LOGGER_DEFINES_SVH

`define ODD_PARITY 1'b1
`define LANE_COUNT 2
`define RPT_LOW_FLAG 0
`define RPT_HIGH_FLAG 1
`define RPT_BANK_LSB 2
`define RPT_BANK_MSB 3
`define RPT_UPPER_ZERO 4'h0
`define BANK_FIELD_HI 8
`define BANK_FIELD_LO 7
`define KB_ADDR_HI 23
`define KB_ADDR_LO 10
`define IO_ADDR_HI 15
`define BYTE_HI 15
`define BYTE_LO_HI 7
`define BYTE_HI_LO 8
`define BANK_RST 2'h0
`define DATA_RST 16'h0000
`define INT_RST 8'h00

`endif

// ==== verilog/parity_logger_pkg.sv ====
package parity_logger_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_ACK} phase_t;

  typedef struct packed {
    phase_t phase;
    logic low_flag;
    logic high_flag;
    logic [1:0] bank;
    logic io_rd;
    logic [15:0] dat;
    logic dat_oe;
    logic xack_b;
    logic [7:0] int_oe;
  } state_t;

endpackage
